// ### pcs_pkg.sv
// shared constants and types for the program counter sequencer.
// assumes one system clock; the clock period is the instruction sub-phase time.
package pcs_pkg;

	localparam int PC_W_MAX = 12;
	localparam int CLK_NS = 40;
	localparam int TSYS_NS = CLK_NS;
	localparam int PHASES = 4;
	// wake-up start-up period, in system clock periods
	localparam int SST_TSYS = 1024;
	localparam int SST_CYC = (SST_TSYS * TSYS_NS + CLK_NS - 1) / CLK_NS;

	// register indices; byte address is four times the index
	localparam logic [7:0] REG_PC_LOW_BYTE = 8'h06;
	localparam logic [7:0] REG_TABLE_POINTER = 8'h07;
	localparam logic [7:0] REG_TABLE_HIGH_BYTE = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h11;
	localparam logic [7:0] REG_PC_FULL = 8'h12;
	localparam logic [7:0] REG_LOAD_ADDR = 8'h13;
	localparam logic [7:0] REG_LOAD_DATA = 8'h14;

	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [11:0] VEC_RESET = 12'h000;
	localparam logic [11:0] VEC_EXT = 12'h004;
	localparam logic [11:0] VEC_TMR0 = 12'h008;
	localparam logic [11:0] VEC_TMR1 = 12'h00c;

	typedef enum logic [3:0] {
		PH1 = 4'h1,
		PH2 = 4'h2,
		PH3 = 4'h4,
		PH4 = 4'h8
	} pcs_phase_t;

	typedef enum logic [2:0] {
		S_RUN = 3'h1,
		S_HALT = 3'h2,
		S_START = 3'h4
	} pcs_seq_t;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_JUMP = 4'h1,
		OP_CALL = 4'h2,
		OP_RETURN_FROM_CALL = 4'h3,
		OP_RETURN_FROM_INTERRUPT = 4'h4,
		OP_SKIP = 4'h5,
		OP_TABLE_READ_CURRENT_PAGE = 4'h6,
		OP_TABLE_READ_LAST_PAGE = 4'h7,
		OP_HALT = 4'h8
	} pcs_op_t;

	// decoded instruction class from the execution unit
	typedef struct packed {
		pcs_op_t op;
		logic cond;
		logic [11:0] target;
	} pcs_exec_t;

endpackage

// ### pcs_prog_mem.sv
// program memory: one write port for loading, one registered read port.
// assumes a single clock; contents are undefined until loaded.
`timescale 1ns/1ns
module pcs_prog_mem #(
	parameter int AW = 12,
	parameter int DW = 15
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);

	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_q;

	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		rdata_q <= mem[raddr_i];
	end

	assign rdata_o = rdata_q;

endmodule

// ### pcs_sequencer.sv
// program counter sequencer: four-phase cycle, fetch/execute overlap,
// transfers, skips, table reads, interrupt vectors and wake-up delay.
// assumes an execution unit on the same clock and an external stack.
`timescale 1ns/1ns
module pcs_sequencer #(
	parameter int PC_W = pcs_pkg::PC_W_MAX
) (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic [9:0] ADDRESS_I,
	input wire logic READ_I,
	input wire logic WRITE_I,
	input wire logic [3:0] BYTEENABLE_I,
	input wire logic [31:0] WRITEDATA_I,
	output logic [31:0] READDATA_O,
	output logic WAITREQUEST_O,
	input wire pcs_pkg::pcs_exec_t EXEC_I,
	input wire logic INT_N_I,
	input wire logic TMR0_OVF_I,
	input wire logic TMR1_OVF_I,
	input wire logic WAKE_I,
	input wire logic STACK_FULL_I,
	input wire logic [PC_W-1:0] STACK_TOP_I,
	output logic STACK_PUSH_O,
	output logic STACK_POP_O,
	output logic [PC_W-1:0] STACK_DATA_O,
	output logic [3:0] PHASE_O,
	output logic [PC_W-1:0] PC_O,
	output logic [14:0] INSTR_O,
	output logic INSTR_VALID_O,
	output logic [7:0] TBL_LOW_O,
	output logic TBL_LOW_VALID_O,
	output logic [2:0] INT_ACK_O,
	output logic HALTED_O
);

	// word width follows the variant
	localparam int DW = (PC_W == 12) ? 15 : 14;

	pcs_pkg::pcs_phase_t ph_q;
	pcs_pkg::pcs_seq_t seq_q;
	logic [10:0] sst_q;
	logic [PC_W-1:0] pc_q;
	logic [DW-1:0] fetch_q;
	logic [DW-1:0] instr_q;
	logic ir_valid_q;
	logic tbl_q;
	logic tbl_last_q;
	logic [7:0] table_pointer_reg_q;
	logic [7:0] table_high_byte_q;
	logic [7:0] tbl_low_q;
	logic tbl_low_v_q;
	logic pcl_pend_q;
	logic [7:0] pcl_data_q;
	logic push_q;
	logic pop_q;
	logic [PC_W-1:0] sdata_q;
	logic [2:0] ack_q;
	logic [2:0] pend_q;
	logic [2:0] en_q;
	logic int_s1_q;
	logic int_s2_q;
	logic int_s3_q;
	logic wait_q;
	logic halted_q;
	logic [31:0] rdata_q;
	logic [PC_W-1:0] ld_addr_q;
	logic [DW-1:0] mem_rdata;
	logic [PC_W-1:0] mem_raddr;
	logic [PC_W-1:0] tbl_addr;

	function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
		hit = (idx == reg_idx);
	endfunction

	// fixed priority: external, timer zero, timer one
	function automatic logic [2:0] pick(input logic [2:0] req);
		if (req[0])
			pick = 3'h1;
		else if (req[1])
			pick = 3'h2;
		else if (req[2])
			pick = 3'h4;
		else
			pick = 3'h0;
	endfunction

	wire logic [7:0] idx = ADDRESS_I[9:2];
	wire logic req = READ_I | WRITE_I;
	wire logic acc = req & ~wait_q;
	wire logic wr_lo = acc & WRITE_I & BYTEENABLE_I[0];
	wire logic run = (seq_q == pcs_pkg::S_RUN);
	wire logic end_c = run & (ph_q == pcs_pkg::PH4);
	wire logic exec_go = end_c & ir_valid_q;
	wire pcs_pkg::pcs_op_t op = EXEC_I.op;
	wire logic is_ret = (op == pcs_pkg::OP_RETURN_FROM_CALL) |
		(op == pcs_pkg::OP_RETURN_FROM_INTERRUPT);
	wire logic xfer_go = exec_go & ((op == pcs_pkg::OP_JUMP) | (op == pcs_pkg::OP_CALL) | is_ret);
	wire logic skip_go = exec_go & (op == pcs_pkg::OP_SKIP) & EXEC_I.cond;
	wire logic tbl_go = exec_go & ((op == pcs_pkg::OP_TABLE_READ_CURRENT_PAGE) |
		(op == pcs_pkg::OP_TABLE_READ_LAST_PAGE));
	wire logic halt_go = exec_go & (op == pcs_pkg::OP_HALT);
	wire logic busy = xfer_go | skip_go | tbl_go | halt_go;
	// only at the end of an executed word, so a transfer's dummy cycle stays single
	wire logic pcl_go = exec_go & pcl_pend_q & ~busy & ~tbl_q;
	wire logic [2:0] irq_sel = pick(pend_q & en_q);
	wire logic int_go = exec_go & ~busy & ~pcl_go & (|irq_sel) & ~STACK_FULL_I;
	wire logic [2:0] events = {TMR1_OVF_I & (PC_W > 10), TMR0_OVF_I, ~int_s2_q & int_s3_q};
	wire logic fetch_ph = run & (ph_q == pcs_pkg::PH2) & ~tbl_q;

	// pin synchroniser; edge detect only reads the second stage onward
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			int_s1_q <= 1'b1;
			int_s2_q <= 1'b1;
			int_s3_q <= 1'b1;
		end
		else
		begin
			int_s1_q <= INT_N_I;
			int_s2_q <= int_s1_q;
			int_s3_q <= int_s2_q;
		end
	end

	// requests stay recorded while the stack is full; a new event beats the ack
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
			pend_q <= 3'h0;
		else
			pend_q <= (pend_q & ~(int_go ? irq_sel : 3'h0)) | events;
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
			ph_q <= pcs_pkg::PH1;
		else if (!run)
			ph_q <= pcs_pkg::PH1;
		else
		begin
			case (ph_q)
				pcs_pkg::PH1: ph_q <= pcs_pkg::PH2;
				pcs_pkg::PH2: ph_q <= pcs_pkg::PH3;
				pcs_pkg::PH3: ph_q <= pcs_pkg::PH4;
				default: ph_q <= pcs_pkg::PH1;
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			seq_q <= pcs_pkg::S_RUN;
			sst_q <= 11'h000;
			halted_q <= 1'b0;
		end
		else
		begin
			case (seq_q)
				pcs_pkg::S_RUN:
				begin
					if (halt_go)
					begin
						seq_q <= pcs_pkg::S_HALT;
						halted_q <= 1'b1;
					end
				end
				pcs_pkg::S_HALT:
				begin
					sst_q <= 11'h000;
					if (WAKE_I | (|(pend_q & en_q)))
						seq_q <= pcs_pkg::S_START;
				end
				pcs_pkg::S_START:
				begin
					sst_q <= sst_q + 11'h001;
					if (sst_q == 11'(pcs_pkg::SST_CYC - 1))
					begin
						seq_q <= pcs_pkg::S_RUN;
						halted_q <= 1'b0;
					end
				end
				default:
				begin
					seq_q <= pcs_pkg::S_RUN;
					halted_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
			pc_q <= pcs_pkg::VEC_RESET[PC_W-1:0];
		else if (xfer_go)
			pc_q <= is_ret ? STACK_TOP_I : EXEC_I.target[PC_W-1:0];
		else if (pcl_go)
			pc_q <= {pc_q[PC_W-1:8], pcl_data_q};
		else if (int_go)
		begin
			// upper bits stay zero whatever the width
			if (irq_sel[0])
				pc_q <= pcs_pkg::VEC_EXT[PC_W-1:0];
			else if (irq_sel[1])
				pc_q <= pcs_pkg::VEC_TMR0[PC_W-1:0];
			else
				pc_q <= pcs_pkg::VEC_TMR1[PC_W-1:0];
		end
		else if (fetch_ph)
			pc_q <= pc_q + 1'b1;
	end

	// the word fetched alongside a transfer is dropped; a table read keeps it
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			fetch_q <= '0;
			instr_q <= '0;
			ir_valid_q <= 1'b0;
			tbl_q <= 1'b0;
			tbl_last_q <= 1'b0;
		end
		else
		begin
			if (fetch_ph)
				fetch_q <= mem_rdata;
			if (end_c)
			begin
				instr_q <= fetch_q;
				tbl_q <= tbl_go;
				if (tbl_go)
					tbl_last_q <= (op == pcs_pkg::OP_TABLE_READ_LAST_PAGE);
				if (tbl_q)
					ir_valid_q <= 1'b1;
				else
					ir_valid_q <= ~(xfer_go | skip_go | tbl_go | pcl_go | int_go);
			end
		end
	end

	// table address: pointer in the low byte, page or all ones above
	assign tbl_addr = tbl_last_q ? {{(PC_W-8){1'b1}}, table_pointer_reg_q} : {pc_q[PC_W-1:8], table_pointer_reg_q};
	assign mem_raddr = tbl_q ? tbl_addr : pc_q;

	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			table_high_byte_q <= 8'h00;
			tbl_low_q <= 8'h00;
			tbl_low_v_q <= 1'b0;
		end
		else
		begin
			tbl_low_v_q <= 1'b0;
			if (run && ph_q == pcs_pkg::PH2 && tbl_q)
			begin
				tbl_low_q <= mem_rdata[7:0];
				table_high_byte_q <= 8'(mem_rdata[DW-1:8]);
				tbl_low_v_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			push_q <= 1'b0;
			pop_q <= 1'b0;
			sdata_q <= '0;
			ack_q <= 3'h0;
		end
		else
		begin
			push_q <= (xfer_go & (op == pcs_pkg::OP_CALL)) | int_go;
			pop_q <= xfer_go & is_ret;
			// return to the prefetched word that the transfer discards
			sdata_q <= pc_q - 1'b1;
			ack_q <= int_go ? irq_sel : 3'h0;
		end
	end

	// one wait cycle per access keeps the read mux off the bus path
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			wait_q <= ~(req & wait_q);
			if (req && wait_q)
			begin
				if (hit(idx, pcs_pkg::REG_PC_LOW_BYTE))
					rdata_q <= {24'h00_0000, pc_q[7:0]};
				else if (hit(idx, pcs_pkg::REG_TABLE_POINTER))
					rdata_q <= {24'h00_0000, table_pointer_reg_q};
				else if (hit(idx, pcs_pkg::REG_TABLE_HIGH_BYTE))
					rdata_q <= {24'h00_0000, table_high_byte_q};
				else if (hit(idx, pcs_pkg::REG_CTRL))
					rdata_q <= {29'h0000_0000, en_q};
				else if (hit(idx, pcs_pkg::REG_STATUS))
					rdata_q <= {27'h000_0000, seq_q == pcs_pkg::S_START,
						seq_q == pcs_pkg::S_HALT, pend_q};
				else if (hit(idx, pcs_pkg::REG_PC_FULL))
					rdata_q <= 32'(pc_q);
				else if (hit(idx, pcs_pkg::REG_LOAD_ADDR))
					rdata_q <= 32'(ld_addr_q);
				else
					rdata_q <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			table_pointer_reg_q <= 8'h00;
			en_q <= pcs_pkg::CTRL_RESET;
			ld_addr_q <= '0;
		end
		else
		begin
			if (wr_lo && hit(idx, pcs_pkg::REG_TABLE_POINTER))
				table_pointer_reg_q <= WRITEDATA_I[7:0];
			if (wr_lo && hit(idx, pcs_pkg::REG_CTRL))
				en_q <= WRITEDATA_I[2:0];
			if (wr_lo && hit(idx, pcs_pkg::REG_LOAD_ADDR))
				ld_addr_q <= WRITEDATA_I[PC_W-1:0];
			else if (wr_lo && hit(idx, pcs_pkg::REG_LOAD_DATA))
				ld_addr_q <= ld_addr_q + 1'b1;
		end
	end

	// a software write to the low byte waits for the end of the next executed word that is not a transfer, taken skip, table read or halt
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			pcl_pend_q <= 1'b0;
			pcl_data_q <= 8'h00;
		end
		else
		begin
			if (wr_lo && hit(idx, pcs_pkg::REG_PC_LOW_BYTE))
			begin
				pcl_pend_q <= 1'b1;
				pcl_data_q <= WRITEDATA_I[7:0];
			end
			else if (pcl_go)
				pcl_pend_q <= 1'b0;
		end
	end

	pcs_prog_mem #(
		.AW(PC_W),
		.DW(DW)
	) u_mem (
		.clk_i(CLK_I),
		.we_i(wr_lo & hit(idx, pcs_pkg::REG_LOAD_DATA)),
		.waddr_i(ld_addr_q),
		.wdata_i(WRITEDATA_I[DW-1:0]),
		.raddr_i(mem_raddr),
		.rdata_o(mem_rdata)
	);

	assign READDATA_O = rdata_q;
	assign WAITREQUEST_O = wait_q;
	assign STACK_PUSH_O = push_q;
	assign STACK_POP_O = pop_q;
	assign STACK_DATA_O = sdata_q;
	assign PHASE_O = ph_q;
	assign PC_O = pc_q;
	assign INSTR_O = 15'(instr_q);
	assign INSTR_VALID_O = ir_valid_q;
	assign TBL_LOW_O = tbl_low_q;
	assign TBL_LOW_VALID_O = tbl_low_v_q;
	assign INT_ACK_O = ack_q;
	assign HALTED_O = halted_q;

	property p_phase_cycle;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(ph_q == pcs_pkg::PH1 && run) |=> ph_q == pcs_pkg::PH2 ##1 ph_q == pcs_pkg::PH3
			##1 ph_q == pcs_pkg::PH4 ##1 ph_q == pcs_pkg::PH1;
	endproperty
	a_phase_cycle: assert property (p_phase_cycle) else $error("phase order broken");

	property p_pc_inc;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		fetch_ph |=> pc_q == $past(pc_q) + 1'b1;
	endproperty
	a_pc_inc: assert property (p_pc_inc) else $error("pc not incremented after fetch");

	property p_xfer_dummy;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		xfer_go |=> !ir_valid_q [*4] ##1 ir_valid_q;
	endproperty
	a_xfer_dummy: assert property (p_xfer_dummy) else $error("transfer without dummy");

	property p_skip;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		skip_go |=> !ir_valid_q && pc_q == $past(pc_q);
	endproperty
	a_skip: assert property (p_skip) else $error("skip did not discard word");

	property p_reset_pc;
		@(posedge CLK_I) !RESET_N_I |=> pc_q == '0 && !ir_valid_q;
	endproperty
	a_reset_pc: assert property (p_reset_pc) else $error("reset pc not zero");

	property p_vec_ext;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		INT_ACK_O[0] |-> pc_q == pcs_pkg::VEC_EXT[PC_W-1:0] && STACK_PUSH_O;
	endproperty
	a_vec_ext: assert property (p_vec_ext) else $error("external vector wrong");

	property p_vec_t0;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		INT_ACK_O[1] |-> pc_q == pcs_pkg::VEC_TMR0[PC_W-1:0];
	endproperty
	a_vec_t0: assert property (p_vec_t0) else $error("timer zero vector wrong");

	property p_vec_t1;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		INT_ACK_O[2] |-> pc_q == pcs_pkg::VEC_TMR1[PC_W-1:0];
	endproperty
	a_vec_t1: assert property (p_vec_t1) else $error("timer one vector wrong");

	property p_pcl_page;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		pcl_go |=> pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8]) && pc_q[7:0] == $past(pcl_data_q);
	endproperty
	a_pcl_page: assert property (p_pcl_page) else $error("short jump left page");

	property p_full_hold;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		STACK_FULL_I |=> INT_ACK_O == 3'h0;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("ack with full stack");

	property p_startup;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		$fell(seq_q == pcs_pkg::S_START) |-> $past(sst_q) == 11'(pcs_pkg::SST_CYC - 1);
	endproperty
	a_startup: assert property (p_startup) else $error("start-up period wrong");

	property p_tbl_two;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		tbl_go |=> tbl_q [*4] ##1 (!tbl_q && ir_valid_q && TBL_LOW_VALID_O == 1'b0);
	endproperty
	a_tbl_two: assert property (p_tbl_two) else $error("table read not two cycles");

	property p_tbl_last;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(tbl_q && tbl_last_q) |-> mem_raddr[PC_W-1:8] == {(PC_W-8){1'b1}};
	endproperty
	a_tbl_last: assert property (p_tbl_last) else $error("last page address wrong");

	c_interrupt: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) int_go);
	c_table: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) tbl_go ##5 tbl_low_v_q);
	c_wake: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) $fell(HALTED_O));
	c_pcl: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) pcl_go);

endmodule

// ### pcs_stack_model.sv
// return-address stack standing beside the sequencer.
// assumes push and pop are one-cycle pulses on the system clock.
`timescale 1ns/1ns
module pcs_stack_model #(
	parameter int PC_W = 12,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [PC_W-1:0] data_i,
	output logic full_o,
	output logic [PC_W-1:0] top_o
);
	logic [PC_W-1:0] mem_q [DEPTH];
	int cnt_q;
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			cnt_q <= 0;
		else if (push_i && cnt_q < DEPTH)
		begin
			mem_q[cnt_q] <= data_i;
			cnt_q <= cnt_q + 1;
		end
		else if (pop_i && cnt_q > 0)
			cnt_q <= cnt_q - 1;
	end
	assign full_o = (cnt_q == DEPTH);
	// an empty stack shows no stale entry
	assign top_o = (cnt_q > 0) ? mem_q[cnt_q-1] : ~mem_q[0];
endmodule

// ### test_program_counter_sequencer.sv
// self-checking bench for the program counter sequencer.
// assumes the stack model as far side; the bench plays execution unit and timers.
`timescale 1ns/1ns
module test_program_counter_sequencer;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] addr = 10'h000;
	logic rd = 1'b0, wr = 1'b0, int_n = 1'b1, t0 = 1'b0, t1 = 1'b0, wake = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic wait_req, sfull, push, pop, ivalid, tlowv, halted;
	pcs_pkg::pcs_exec_t exec_v = '0;
	logic [11:0] top, sdata, pc, e, ts;
	logic [3:0] phase;
	logic [14:0] instr, w;
	logic [7:0] tlow;
	logic [2:0] ack;
	int num_errors = 0, cmp_count = 0, cycles = 0, g;

	always #20 clk = ~clk;

	pcs_sequencer #(.PC_W(12)) i_pcs_sequencer (
		.CLK_I(clk),
		.RESET_N_I(rst_n),
		.ADDRESS_I(addr),
		.READ_I(rd),
		.WRITE_I(wr),
		.BYTEENABLE_I(4'hf),
		.WRITEDATA_I(wdata),
		.READDATA_O(rdata),
		.WAITREQUEST_O(wait_req),
		.EXEC_I(exec_v),
		.INT_N_I(int_n),
		.TMR0_OVF_I(t0),
		.TMR1_OVF_I(t1),
		.WAKE_I(wake),
		.STACK_FULL_I(sfull),
		.STACK_TOP_I(top),
		.STACK_PUSH_O(push),
		.STACK_POP_O(pop),
		.STACK_DATA_O(sdata),
		.PHASE_O(phase),
		.PC_O(pc),
		.INSTR_O(instr),
		.INSTR_VALID_O(ivalid),
		.TBL_LOW_O(tlow),
		.TBL_LOW_VALID_O(tlowv),
		.INT_ACK_O(ack),
		.HALTED_O(halted)
	);

	pcs_stack_model #(.PC_W(12), .DEPTH(4)) i_pcs_stack_model (
		.clk_i(clk),
		.reset_n_i(rst_n),
		.push_i(push),
		.pop_i(pop),
		.data_i(sdata),
		.full_o(sfull),
		.top_o(top)
	);

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// whole run needs about 2000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			finish_test();
		end
	end

	function automatic logic [14:0] wd(input logic [11:0] a);
		return 15'h1000 | {3'h0, a};
	endfunction

	task automatic bus(input logic w_en, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk);
		addr <= {idx, 2'h0};
		wr <= w_en;
		rd <= !w_en;
		wdata <= d;
		do @(posedge clk); while (wait_req !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	// op is presented for the PH4 cycle of a valid instruction
	task automatic exec_op(input pcs_pkg::pcs_op_t op, input logic c, input logic [11:0] t);
		do @(negedge clk); while (!(phase === 4'h4 && ivalid === 1'b1));
		e = instr[11:0];
		@(posedge clk);
		exec_v <= '{op, c, t};
		@(posedge clk);
		exec_v <= '0;
		@(negedge clk);
	endtask

	task automatic next_valid();
		g = 0;
		while (ivalid !== 1'b1 && g < 64)
		begin
			g++;
			@(negedge clk);
		end
		w = instr;
	endtask

	task automatic wait_ack(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk);
			if (ack !== 3'h0)
				break;
		end
	endtask

	task automatic t_flow();
		do @(negedge clk); while (phase !== 4'h1);
		for (int i = 0; i < 8; i++)
		begin
			chk("phase", 32'h1 << (i % 4), {28'h0, phase});
			@(negedge clk);
		end
		exec_op(pcs_pkg::OP_JUMP, 1'b0, 12'h010);
		chk("jump pc", 32'h010, {20'h0, pc});
		next_valid();
		chk("jump dummy", 32'd4, g);
		chk("jump word", {17'h0, wd(12'h010)}, {17'h0, w});
		exec_op(pcs_pkg::OP_NONE, 1'b0, 12'h000);
		next_valid();
		chk("plain gap", 32'd0, g);
		chk("plain word", {17'h0, wd(e + 12'h1)}, {17'h0, w});
		exec_op(pcs_pkg::OP_SKIP, 1'b0, 12'h000);
		next_valid();
		chk("skip false", {17'h0, wd(e + 12'h1)}, {17'h0, w});
		exec_op(pcs_pkg::OP_SKIP, 1'b1, 12'h000);
		next_valid();
		chk("skip dummy", 32'd4, g);
		chk("skip word", {17'h0, wd(e + 12'h2)}, {17'h0, w});
		exec_op(pcs_pkg::OP_CALL, 1'b0, 12'h030);
		chk("call push", 32'h1, {31'h0, push});
		chk("call return", {20'h0, e + 12'h1}, {20'h0, sdata});
		chk("call pc", 32'h030, {20'h0, pc});
	endtask

	task automatic t_pcl();
		bus(1'b1, pcs_pkg::REG_PC_LOW_BYTE, 32'h40);
		g = 0;
		while (!(ivalid === 1'b1 && instr === wd(12'h040)) && g < 24)
		begin
			g++;
			@(negedge clk);
		end
		chk("short jump", 32'h1, {31'h0, g < 24});
		bus(1'b0, 8'h3f, 32'h0);
		chk("unmapped read", 32'h0, q);
	endtask

	task automatic t_table(input pcs_pkg::pcs_op_t op, input logic [7:0] lo, input logic [31:0] hi);
		bus(1'b1, pcs_pkg::REG_TABLE_POINTER, 32'h5a);
		exec_op(op, 1'b0, 12'h000);
		g = 0;
		while (tlowv !== 1'b1 && g < 8)
		begin
			g++;
			@(negedge clk);
		end
		chk("table strobe", 32'h1, {31'h0, tlowv});
		chk("table low", {24'h0, lo}, {24'h0, tlow});
		next_valid();
		chk("table word", {17'h0, wd(e + 12'h1)}, {17'h0, w});
		bus(1'b0, pcs_pkg::REG_TABLE_HIGH_BYTE, 32'h0);
		chk("table high", hi, q);
	endtask

	task automatic t_irq(input int k, input logic [11:0] vec);
		bus(1'b1, pcs_pkg::REG_CTRL, 32'h1 << k);
		@(posedge clk);
		int_n <= (k != 0);
		t0 <= (k == 1);
		t1 <= (k == 2);
		@(posedge clk);
		t0 <= 1'b0;
		t1 <= 1'b0;
		wait_ack(24);
		chk("ack", 32'h1 << k, {29'h0, ack});
		chk("vector", {20'h0, vec}, {20'h0, pc});
		chk("irq push", 32'h1, {31'h0, push});
		@(posedge clk);
		int_n <= 1'b1;
		next_valid();
		chk("vector word", {17'h0, wd(vec)}, {17'h0, w});
	endtask

	task automatic t_full();
		chk("stack full", 32'h1, {31'h0, sfull});
		bus(1'b1, pcs_pkg::REG_CTRL, 32'h2);
		@(posedge clk);
		t0 <= 1'b1;
		@(posedge clk);
		t0 <= 1'b0;
		wait_ack(40);
		chk("held ack", 32'h0, {29'h0, ack});
		ts = top;
		exec_op(pcs_pkg::OP_RETURN_FROM_INTERRUPT, 1'b0, 12'h000);
		chk("return pc", {20'h0, ts}, {20'h0, pc});
		chk("return pop", 32'h1, {31'h0, pop});
		wait_ack(24);
		chk("late ack", 32'h2, {29'h0, ack});
		chk("late vector", 32'h008, {20'h0, pc});
		bus(1'b1, pcs_pkg::REG_CTRL, 32'h0);
	endtask

	task automatic t_halt();
		exec_op(pcs_pkg::OP_HALT, 1'b0, 12'h000);
		repeat (20) @(negedge clk);
		chk("halted", 32'h1, {31'h0, halted});
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		g = 0;
		while (halted === 1'b1 && g < 1100)
		begin
			g++;
			@(negedge clk);
		end
		chk("start-up", 32'h1, {31'h0, g >= 1023 && g <= 1027});
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		chk("reset pc", 32'h0, {20'h0, pc});
		chk("reset phase", 32'h1, {28'h0, phase});
		@(posedge clk);
		rst_n <= 1'b1;
		bus(1'b1, pcs_pkg::REG_LOAD_ADDR, 32'h0);
		for (int a = 0; a < 128; a++)
			bus(1'b1, pcs_pkg::REG_LOAD_DATA, {17'h0, wd(a[11:0])});
		bus(1'b1, pcs_pkg::REG_LOAD_ADDR, 32'hf5a);
		bus(1'b1, pcs_pkg::REG_LOAD_DATA, 32'h5abc);
		t_flow();
		t_pcl();
		t_table(pcs_pkg::OP_TABLE_READ_LAST_PAGE, 8'hbc, 32'h5a);
		t_table(pcs_pkg::OP_TABLE_READ_CURRENT_PAGE, 8'h5a, 32'h10);
		t_irq(0, 12'h004);
		t_irq(1, 12'h008);
		t_irq(2, 12'h00c);
		t_full();
		t_halt();
		// second reset in mid-run restarts from word zero
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		next_valid();
		chk("restart word", {17'h0, wd(12'h000)}, {17'h0, w});
		finish_test();
	end
endmodule
